//--- logic/icc_input_check_config.sv
`timescale 1ns/1ps
`default_nettype none
module icc_input_check_config #(
    parameter int CHANNELS = icc_pkg::CHANNELS,
    parameter int CHAN_W   = icc_pkg::CHAN_W
) (
    input  wire logic                        core_clk,
    input  wire logic                        rst,
    input  wire logic [icc_pkg::ADDR_W-1:0]  regAddr,
    input  wire logic [icc_pkg::REG_W-1:0]   regWrData,
    input  wire logic                        regWrite,
    input  wire logic                        regRead,
    output logic [icc_pkg::REG_W-1:0]        regRdData,
    input  wire logic [CHANNELS*CHAN_W-1:0]  dataPins,
    input  wire logic                        validPin,
    input  wire icc_pkg::icc_aux_s           auxPins,
    input  wire logic                        transmitEnablePin,
    input  wire logic                        sifTxEnable,
    input  wire logic [CHANNELS*CHAN_W-1:0]  expectWord,
    input  wire logic                        alarmClear,
    input  wire icc_pkg::icc_fifo_s          fifoRaw,
    output logic [CHANNELS*CHAN_W-1:0]       sampleOut,
    output logic                             sampleOutValid,
    output logic                             syncOut,
    output logic                             strobeOut,
    output logic                             analogEnable,
    output icc_pkg::icc_fifo_s               fifoAlarm,
    output logic                             parityAlarm,
    output logic                             patternAlarm
);
    localparam int WORD_W = CHANNELS * CHAN_W;
    localparam int SYNC_W = WORD_W + 5;

    logic [icc_pkg::REG_W-1:0]      inputCheckControl;
    logic [icc_pkg::REG_W-1:0]      next_inputCheckControl;
    logic [icc_pkg::REG_W-1:0]      next_regRdData;
    icc_pkg::icc_ctrl_s             ctrl;
    logic [SYNC_W-1:0]              pinMeta;
    logic [SYNC_W-1:0]              pinSync;
    logic [WORD_W-1:0]              dataS;
    logic                           validS;
    icc_pkg::icc_aux_s              auxS;
    icc_pkg::icc_aux_s              effAux;
    logic                           txPinS;
    logic [WORD_W-1:0]              invertMask;
    logic [WORD_W-1:0]              next_sampleOut;
    logic                           next_analogEnable;
    icc_pkg::icc_fifo_s             next_fifoAlarm;
    logic                           sampleGood;
    logic [icc_pkg::GOOD_CNT_W-1:0] goodCount;

    // register file
    always_comb begin
        next_inputCheckControl = inputCheckControl;
        next_regRdData         = '0;
        if (regWrite && regAddr == icc_pkg::CTRL_ADDR) begin
            next_inputCheckControl = regWrData & icc_pkg::CTRL_WMASK;
        end
        if (regRead && regAddr == icc_pkg::CTRL_ADDR) begin
            next_regRdData = inputCheckControl;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            inputCheckControl <= icc_pkg::CTRL_RESET;
            regRdData         <= '0;
        end else begin
            inputCheckControl <= next_inputCheckControl;
            regRdData         <= next_regRdData;
        end
    end

    always_comb begin
        ctrl.patternTest          = inputCheckControl[icc_pkg::PATTERN_BIT];
        ctrl.autoAlarmClearEnable = inputCheckControl[icc_pkg::AUTOCLR_BIT];
        ctrl.oddParity            = inputCheckControl[icc_pkg::ODDPAR_BIT];
        ctrl.lineParity           = inputCheckControl[icc_pkg::LINEPAR_BIT];
        ctrl.strobeParity         = inputCheckControl[icc_pkg::STRBPAR_BIT];
        ctrl.rotate               = inputCheckControl[icc_pkg::ROTATE_BIT];
        ctrl.chanInvert           = inputCheckControl[icc_pkg::INV_LO_BIT +: 4];
        ctrl.nearTwoAlarmEnable   = inputCheckControl[icc_pkg::NEAR2_BIT];
        ctrl.nearOneAlarmEnable   = inputCheckControl[icc_pkg::NEAR1_BIT];
        ctrl.collisionAlarmEnable = inputCheckControl[icc_pkg::COLL_BIT];
    end

    // pin synchroniser; only the second stage is read
    always_ff @(posedge core_clk) begin
        if (rst) begin
            pinMeta <= '0;
            pinSync <= '0;
        end else begin
            pinMeta <= {dataPins, validPin, auxPins, transmitEnablePin};
            pinSync <= pinMeta;
        end
    end

    always_comb begin
        {dataS, validS, auxS, txPinS} = pinSync;
        effAux = auxS;
        if (ctrl.rotate) begin
            effAux.strobe = auxS.sync;
            effAux.sync   = auxS.parity;
            effAux.parity = auxS.strobe;
        end
        // per channel complement, channel A in the top slice
        for (int c = 0; c < CHANNELS; c++) begin
            invertMask[c*CHAN_W +: CHAN_W] = {CHAN_W{ctrl.chanInvert[c]}};
        end
        next_sampleOut    = dataS ^ invertMask;
        next_analogEnable = txPinS && sifTxEnable && !ctrl.patternTest;
        next_fifoAlarm.nearTwo   = fifoRaw.nearTwo && ctrl.nearTwoAlarmEnable;
        next_fifoAlarm.nearOne   = fifoRaw.nearOne && ctrl.nearOneAlarmEnable;
        next_fifoAlarm.collision = fifoRaw.collision && ctrl.collisionAlarmEnable;
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            sampleOut      <= '0;
            sampleOutValid <= 1'b0;
            syncOut        <= 1'b0;
            strobeOut      <= 1'b0;
            analogEnable   <= 1'b0;
            fifoAlarm      <= '0;
        end else begin
            sampleOut      <= next_sampleOut;
            sampleOutValid <= validS;
            syncOut        <= effAux.sync;
            strobeOut      <= effAux.strobe;
            analogEnable   <= next_analogEnable;
            fifoAlarm      <= next_fifoAlarm;
        end
    end

    icc_input_checker #(
        .WORD_W (WORD_W)
    ) icc_input_checker_i (
        .core_clk        (core_clk),
        .rst             (rst),
        .sampleValid     (validS),
        .word            (dataS),
        .expectWord      (expectWord),
        .lineParityBit   (effAux.parity),
        .strobeParityBit (effAux.strobe),
        .ctrl            (ctrl),
        .alarmClear      (alarmClear),
        .sampleGood      (sampleGood),
        .goodCount       (goodCount),
        .parityAlarm     (parityAlarm),
        .patternAlarm    (patternAlarm)
    );

    reg_reset_a: assert property (@(posedge core_clk)
        rst |=> regRdData == '0 && inputCheckControl == icc_pkg::CTRL_RESET)
        else $error("control register reset value wrong");

    reserved_read_a: assert property (@(posedge core_clk) disable iff (rst)
        regRead && regAddr == icc_pkg::CTRL_ADDR
        |=> regRdData == ($past(inputCheckControl) & icc_pkg::CTRL_WMASK))
        else $error("register read data or reserved bits wrong");

    pattern_flag_a: assert property (@(posedge core_clk) disable iff (rst)
        validS && ctrl.patternTest && dataS != expectWord |=> patternAlarm)
        else $error("pattern mismatch not flagged");

    outputs_off_a: assert property (@(posedge core_clk) disable iff (rst)
        ctrl.patternTest |=> !analogEnable)
        else $error("analog outputs on during pattern test");

    auto_clear_a: assert property (@(posedge core_clk) disable iff (rst)
        ctrl.autoAlarmClearEnable && sampleGood && goodCount == 6'h3f && !alarmClear
        |=> !parityAlarm && !patternAlarm)
        else $error("alarms not cleared after good run");

    line_parity_a: assert property (@(posedge core_clk) disable iff (rst)
        validS && ctrl.lineParity && ((^dataS ^ effAux.parity) != ctrl.oddParity)
        |=> parityAlarm)
        else $error("line parity error missed");

    parity_sense_a: assert property (@(posedge core_clk) disable iff (rst)
        validS && ctrl.lineParity && !ctrl.strobeParity && !ctrl.patternTest
        && ((^dataS ^ effAux.parity) == ctrl.oddParity)
        |-> sampleGood)
        else $error("matching parity judged bad");

    strobe_parity_a: assert property (@(posedge core_clk) disable iff (rst)
        validS && ctrl.strobeParity && ((^dataS ^ effAux.strobe) != ctrl.oddParity)
        |=> parityAlarm)
        else $error("strobe parity error missed");

    rotate_roles_a: assert property (@(posedge core_clk) disable iff (rst)
        ctrl.rotate |=> syncOut == $past(auxS.parity) && strobeOut == $past(auxS.sync))
        else $error("rotated roles wrong");

    chan_invert_a: assert property (@(posedge core_clk) disable iff (rst)
        ctrl.chanInvert[CHANNELS-1]
        |=> sampleOut[WORD_W-1 -: CHAN_W] == ~$past(dataS[WORD_W-1 -: CHAN_W]))
        else $error("channel A not complemented");

    near_two_a: assert property (@(posedge core_clk) disable iff (rst)
        fifoAlarm.nearTwo |-> $past(fifoRaw.nearTwo && ctrl.nearTwoAlarmEnable))
        else $error("two-apart alarm leaks");

    near_one_a: assert property (@(posedge core_clk) disable iff (rst)
        fifoRaw.nearOne && ctrl.nearOneAlarmEnable |=> fifoAlarm.nearOne)
        else $error("one-apart alarm lost");

    collision_en_a: assert property (@(posedge core_clk) disable iff (rst)
        !ctrl.collisionAlarmEnable |=> !fifoAlarm.collision)
        else $error("collision alarm not masked");

    sticky_parity_a: assert property (@(posedge core_clk) disable iff (rst)
        parityAlarm && !alarmClear && !(ctrl.autoAlarmClearEnable && sampleGood)
        |=> parityAlarm)
        else $error("parity alarm dropped without clear");
endmodule
`default_nettype wire

//--- inc/icc_pkg.sv
package icc_pkg;
    localparam int          REG_W       = 16;
    localparam int          ADDR_W      = 7;
    localparam logic [6:0]  CTRL_ADDR   = 7'h01;
    localparam logic [15:0] CTRL_RESET  = 16'h040e;
    // bits 14, 13 and 0 are reserved and never store
    localparam logic [15:0] CTRL_WMASK  = 16'h9ffe;
    localparam int          PATTERN_BIT = 15;
    localparam int          AUTOCLR_BIT = 12;
    localparam int          ODDPAR_BIT  = 11;
    localparam int          LINEPAR_BIT = 10;
    localparam int          STRBPAR_BIT = 9;
    localparam int          ROTATE_BIT  = 8;
    localparam int          INV_LO_BIT  = 4;
    localparam int          NEAR2_BIT   = 3;
    localparam int          NEAR1_BIT   = 2;
    localparam int          COLL_BIT    = 1;
    localparam int          GOOD_RUN    = 64;
    localparam int          GOOD_CNT_W  = 6;
    localparam int          CHANNELS    = 4;
    localparam int          CHAN_W      = 16;

    typedef struct packed {
        logic sync;
        logic parity;
        logic strobe;
    } icc_aux_s;

    typedef struct packed {
        logic       patternTest;
        logic       autoAlarmClearEnable;
        logic       oddParity;
        logic       lineParity;
        logic       strobeParity;
        logic       rotate;
        logic [3:0] chanInvert;
        logic       nearTwoAlarmEnable;
        logic       nearOneAlarmEnable;
        logic       collisionAlarmEnable;
    } icc_ctrl_s;

    typedef struct packed {
        logic nearTwo;
        logic nearOne;
        logic collision;
    } icc_fifo_s;
endpackage

//--- logic/icc_input_checker.sv
`timescale 1ns/1ps
`default_nettype none
module icc_input_checker #(
    parameter int WORD_W = 64
) (
    input  wire logic                        core_clk,
    input  wire logic                        rst,
    input  wire logic                        sampleValid,
    input  wire logic [WORD_W-1:0]           word,
    input  wire logic [WORD_W-1:0]           expectWord,
    input  wire logic                        lineParityBit,
    input  wire logic                        strobeParityBit,
    input  wire icc_pkg::icc_ctrl_s          ctrl,
    input  wire logic                        alarmClear,
    output logic                             sampleGood,
    output logic [icc_pkg::GOOD_CNT_W-1:0]   goodCount,
    output logic                             parityAlarm,
    output logic                             patternAlarm
);
    logic                           wordParity;
    logic                           parityBad;
    logic                           patternBad;
    logic                           autoClear;
    logic [icc_pkg::GOOD_CNT_W-1:0] next_goodCount;
    logic                           next_parityAlarm;
    logic                           next_patternAlarm;

    always_comb begin
        wordParity = ^word;
        // dedicated line check, sense from bit 11
        parityBad  = ctrl.lineParity
                     && ((wordParity ^ lineParityBit) != ctrl.oddParity);
        if (ctrl.strobeParity && ((wordParity ^ strobeParityBit) != ctrl.oddParity)) begin
            parityBad = 1'b1;
        end
        parityBad  = parityBad && sampleValid;
        patternBad = sampleValid && ctrl.patternTest && (word != expectWord);
        sampleGood = sampleValid && !parityBad && !patternBad;
        autoClear  = ctrl.autoAlarmClearEnable && sampleGood
                     && (goodCount == icc_pkg::GOOD_CNT_W'(icc_pkg::GOOD_RUN - 1));
        next_goodCount = goodCount;
        if (parityBad || patternBad) begin
            next_goodCount = '0;
        end else if (sampleGood) begin
            next_goodCount = goodCount + 1'b1;
        end
        next_parityAlarm  = parityAlarm;
        next_patternAlarm = patternAlarm;
        if (alarmClear || autoClear) begin
            next_parityAlarm  = 1'b0;
            next_patternAlarm = 1'b0;
        end
        if (parityBad) begin
            next_parityAlarm = 1'b1;
        end
        if (patternBad) begin
            next_patternAlarm = 1'b1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            goodCount    <= '0;
            parityAlarm  <= 1'b0;
            patternAlarm <= 1'b0;
        end else begin
            goodCount    <= next_goodCount;
            parityAlarm  <= next_parityAlarm;
            patternAlarm <= next_patternAlarm;
        end
    end
endmodule
`default_nettype wire

//--- verification/icc_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module icc_host_model (
    input  wire logic [63:0]  word,
    input  wire logic         valid,
    input  wire logic         oddParity,
    input  wire logic         useStrobe,
    input  wire logic         badParity,
    input  wire logic         syncLvl,
    input  wire logic         strobeLvl,
    output logic [63:0]       dataPins,
    output logic              validPin,
    output icc_pkg::icc_aux_s auxPins
);
    // host side of the bus: word, qualifier and aux lines
    icc_host_drv icc_host_drv_i (
        .word      (word),
        .valid     (valid),
        .oddParity (oddParity),
        .useStrobe (useStrobe),
        .badParity (badParity),
        .syncLvl   (syncLvl),
        .strobeLvl (strobeLvl),
        .dataPins  (dataPins),
        .validPin  (validPin),
        .auxPins   (auxPins)
    );
endmodule
`default_nettype wire

//--- verification/icc_host_drv.sv
`timescale 1ns/1ps
`default_nettype none
module icc_host_drv (
    input  wire logic [63:0]  word,
    input  wire logic         valid,
    input  wire logic         oddParity,
    input  wire logic         useStrobe,
    input  wire logic         badParity,
    input  wire logic         syncLvl,
    input  wire logic         strobeLvl,
    output logic [63:0]       dataPins,
    output logic              validPin,
    output icc_pkg::icc_aux_s auxPins
);
    logic par;
    always_comb begin
        par = ^word ^ oddParity ^ badParity;
        validPin = valid;
        auxPins.sync = syncLvl;
        if (valid) begin
            dataPins = word;
            auxPins.parity = par;
            auxPins.strobe = useStrobe ? par : strobeLvl;
        end else begin
            // released bus shows inverse of the current word, parity and strobe; sync is not inverted
            dataPins = ~word;
            auxPins.parity = ~par;
            auxPins.strobe = useStrobe ? ~par : ~strobeLvl;
        end
    end
endmodule
`default_nettype wire

//--- verification/test_input_check_config.sv
`timescale 1ns/1ps
`default_nettype none
module test_input_check_config;
    logic core_clk = 0, rst = 1, regWrite = 0, regRead = 0, txPin = 0, sifTx = 0;
    logic alarmClear = 0, hostValid = 1, odd = 0, useStr = 0, bad = 0;
    logic syncLvl = 0, strobeLvl = 0, validPin, sampleOutValid, syncOut, strobeOut;
    logic analogEnable, parityAlarm, patternAlarm;
    logic [6:0] regAddr = 0;
    logic [15:0] regWrData = 0, regRdData;
    logic [63:0] hostWord = 64'h0123456789abcdef, expectWord = 64'h0123456789abcdef;
    logic [63:0] dataPins, sampleOut;
    icc_pkg::icc_aux_s auxPins;
    icc_pkg::icc_fifo_s fifoRaw = 3'h0, fifoAlarm;
    int fail_count = 0, total_checks = 0, cycles = 0, i;

    always #12.5 core_clk = ~core_clk;

    icc_host_model icc_host_model_i (.word(hostWord), .valid(hostValid), .oddParity(odd),
        .useStrobe(useStr), .badParity(bad), .syncLvl(syncLvl), .strobeLvl(strobeLvl),
        .dataPins(dataPins), .validPin(validPin), .auxPins(auxPins));

    icc_input_check_config icc_input_check_config_i (.core_clk(core_clk), .rst(rst),
        .regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
        .regRdData(regRdData), .dataPins(dataPins), .validPin(validPin), .auxPins(auxPins),
        .transmitEnablePin(txPin), .sifTxEnable(sifTx), .expectWord(expectWord),
        .alarmClear(alarmClear), .fifoRaw(fifoRaw), .sampleOut(sampleOut),
        .sampleOutValid(sampleOutValid), .syncOut(syncOut), .strobeOut(strobeOut),
        .analogEnable(analogEnable), .fifoAlarm(fifoAlarm), .parityAlarm(parityAlarm),
        .patternAlarm(patternAlarm));

    task automatic step(input int n);
        repeat (n) @(posedge core_clk);
        #2;
    endtask

    task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string msg);
        total_checks++;
        if (got !== exp) begin
            $display("CHECK FAILED t=%0t %s got %h exp %h", $time, msg, got, exp);
            fail_count++;
        end
    endtask

    task automatic regWr(input logic [6:0] a, input logic [15:0] d);
        regAddr = a;
        regWrData = d;
        regWrite = 1;
        step(1);
        regWrite = 0;
    endtask

    task automatic regRd(input logic [6:0] a, input logic [15:0] exp, input string msg);
        regAddr = a;
        regRead = 1;
        step(1);
        regRead = 0;
        chk(regRdData, exp, msg);
    endtask

    task automatic clearAlarms();
        // let words judged under the old setting drain before clearing
        step(2);
        alarmClear = 1;
        step(1);
        alarmClear = 0;
        step(4);
    endtask

    task automatic stop_test();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 2000) begin
            fail_count++;
            stop_test();
        end
    end

    initial begin
        step(3);
        rst = 0;
        regRd(7'h01, 16'h040e, "reset value");
        regRd(7'h02, 16'h0000, "unmapped read");
        regWr(7'h02, 16'hffff);
        regRd(7'h01, 16'h040e, "unmapped write");
        regWr(7'h01, 16'hffff);
        regRd(7'h01, 16'h9ffe, "reserved bits");
        $display("test registers done");
        txPin = 1;
        sifTx = 1;
        regWr(7'h01, 16'h0400);
        clearAlarms();
        chk(analogEnable, 1, "analog enabled");
        regWr(7'h01, 16'h8400);
        step(4);
        chk(analogEnable, 0, "pattern test forces off");
        chk(patternAlarm, 0, "pattern match");
        expectWord = hostWord ^ 64'h1;
        step(4);
        chk(patternAlarm, 1, "pattern mismatch");
        regWr(7'h01, 16'h0400);
        clearAlarms();
        chk(patternAlarm, 0, "pattern alarm cleared");
        $display("test pattern done");
        for (i = 0; i < 4; i++) begin
            regWr(7'h01, 16'h0400 | (16'h0010 << i));
            step(4);
            chk(sampleOut, hostWord ^ (64'hffff << (16 * i)), "channel invert");
            chk(sampleOutValid, 1, "sample valid passed");
        end
        $display("test invert done");
        fifoRaw = 3'h7;
        for (i = 0; i < 3; i++) begin
            regWr(7'h01, 16'h0002 << i);
            step(2);
            chk(fifoAlarm, 3'h1 << i, "fifo alarm enable");
        end
        fifoRaw = 3'h0;
        $display("test fifo done");
        for (i = 0; i < 4; i++) begin
            odd = i[0];
            useStr = i[1];
            regWr(7'h01, (16'(odd) << 11) | (useStr ? 16'h0200 : 16'h0400));
            clearAlarms();
            chk(parityAlarm, 0, "good parity");
            bad = 1;
            step(4);
            chk(parityAlarm, 1, "bad parity flagged");
            bad = 0;
            step(4);
            chk(parityAlarm, 1, "parity alarm sticky");
        end
        hostValid = 0;
        bad = 1;
        clearAlarms();
        chk(parityAlarm, 0, "no check without valid");
        chk(sampleOutValid, 0, "sample valid low");
        hostValid = 1;
        bad = 0;
        $display("test parity done");
        odd = 0;
        useStr = 0;
        regWr(7'h01, 16'h1400);
        bad = 1;
        step(2);
        bad = 0;
        step(60);
        chk(parityAlarm, 1, "alarm held before 64 good");
        step(10);
        chk(parityAlarm, 0, "auto clear after 64 good");
        $display("test auto clear done");
        regWr(7'h01, 16'h0000);
        syncLvl = 1;
        step(4);
        chk({syncOut, strobeOut}, 2'b10, "roles not rotated");
        regWr(7'h01, 16'h0100);
        step(4);
        chk({syncOut, strobeOut}, {^hostWord, 1'b1}, "roles rotated");
        $display("test rotate done");
        stop_test();
    end
endmodule
`default_nettype wire
